// >>> lios_defines.vh
`ifndef LIOS_DEFINES_VH
`define LIOS_DEFINES_VH
`define LIOS_OM_LEVEL    2'h0
`define LIOS_OM_CYCLIC   2'h1
`define LIOS_OM_PWM      2'h2
`define LIOS_EC_NONE     2'h0
`define LIOS_EC_FALL     2'h1
`define LIOS_EC_RISE     2'h2
`define LIOS_EC_BOTH     2'h3
`define LIOS_IM_EXTREG   2'h0
`define LIOS_IM_ADC      2'h1
`define LIOS_IM_SWOPEN   2'h2
`define LIOS_TR_OFFLINE  2'h0
`define LIOS_TR_ACTIVE   2'h1
`define LIOS_TR_FAILSIL  2'h2
`define LIOS_ZERO8       8'h00
`define LIOS_CH_W        3
`define LIOS_DOM_TO_US   6000
`define LIOS_CLK_MHZ     50
`endif

// >>> lios_io_slave.v
// Notes on behaviour
// RQ1 - Request byte 0 sets pin outputs; ignored for pins in cyclic or PWM mode.
// RQ2 - Third request byte expected only when request length select is set.
// RQ3 - Low three bits of third request byte pick analog channel 0 to 7.
// RQ4 - Analog channel selection applied only while inhibit pin is in ADC mode.
// RQ5 - Response bytes 1,2 carry edge flags and latch, or matrix states if enabled.
// RQ6 - Response byte 3 carries PWM duty, or ADC result in inhibit ADC mode.
// RQ7 - Response bytes 2,3 sent only when response length select is set.
// RQ8 - Per pin drive from high-side enable, low-side enable and output latch.
// RQ9 - Edge capture per pin on none, falling, rising or both edges.
// RQ10 - Threshold bit clear selects high threshold, set selects low threshold.
// RQ11 - Cyclic sense pin with low threshold uses diagnostic threshold instead.
// RQ12 - Inhibit pin starts in external regulator mode, high-side switch on.
// RQ13 - Config pin pull-ups on only during node address configuration.
// RQ14 - Chain config pin has a low-side output for daisy chain passing.
// RQ15 - Transceiver powers up off-line, tx and rx off, wake-up still detected.
// RQ16 - Wake-up in sleep goes to controller; transceiver becomes active.
// RQ17 - Master repeats first frame after sleep unless wake-up preceded it.
// RQ18 - Transmitter enabled only in active state.
// RQ19 - Bus low beyond dominant timeout opens termination, enters fail-silent.
// RQ20 - From fail-silent, recessive bus gives off-line with weak termination.
// RQ21 - Off-line to active always reconnects the resistive pull-up termination.
// RQ22 - Oscillator stopped or slow enters limp home immediately.
// RQ23 - One frame identifier for requests, another for responses.
// RQ24 - Entering any low-power mode clears PWM duty to zero; the code clears it only when low_power_in rises, not on sleep_in.
`include "lios_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module lios_io_slave #(
	parameter DOM_TO_CYC = `LIOS_DOM_TO_US * `LIOS_CLK_MHZ
) (
	input  wire        core_clk_in,
	input  wire        rst_in,
	input  wire        clk_en_in,
	input  wire [5:0]  frame_id_in,
	input  wire [5:0]  request_id_in,
	input  wire [5:0]  response_id_in,
	input  wire        req_byte_valid_in,
	input  wire [1:0]  req_byte_index_in,
	input  wire [7:0]  req_byte_in,
	input  wire        request_length_select_in,
	input  wire        response_length_select_in,
	input  wire        resp_start_in,
	input  wire        resp_byte_ack_in,
	input  wire [15:0] out_mode_in,
	input  wire [7:0]  hs_enable_in,
	input  wire [7:0]  ls_enable_in,
	input  wire [7:0]  low_threshold_select_in,
	input  wire [15:0] edge_mode_in,
	input  wire        matrix_enable_in,
	input  wire [15:0] matrix_switch_states_in,
	input  wire [7:0]  pin_high_th_in,
	input  wire [7:0]  pin_low_th_in,
	input  wire [7:0]  pin_diag_th_in,
	input  wire [7:0]  pwm_wave_in,
	input  wire [7:0]  cyclic_wave_in,
	input  wire [1:0]  inhibit_mode_in,
	input  wire [7:0]  adc_result_in,
	input  wire        nad_config_in,
	input  wire        chain_out_in,
	input  wire        bus_rx_in,
	input  wire        bus_wake_in,
	input  wire        sleep_in,
	input  wire        low_power_in,
	input  wire        osc_fail_in,
	output reg  [7:0]  pin_out,
	output reg  [7:0]  pin_oe_out,
	output reg  [7:0]  pin_in_out,
	output reg         resp_valid_out,
	output reg  [7:0]  resp_byte_out,
	output reg         resp_last_out,
	output reg  [2:0]  analog_channel_select_out,
	output reg  [7:0]  pwm_duty_out,
	output reg  [7:0]  edge_capture_flags_out,
	output reg         inhibit_hs_on_out,
	output reg         inhibit_adc_drive_out,
	output reg  [2:0]  config_pins_pullup_out,
	output reg         chain_config_pin_oe_out,
	output reg         tx_enable_out,
	output reg         rx_enable_out,
	output reg         term_resistor_on_out,
	output reg         term_weak_on_out,
	output reg         wake_to_ctrl_out,
	output reg         limp_home_out
);
	reg  [7:0]  latch_q;
	reg  [2:0]  chan_q;
	reg  [7:0]  prev_in_q;
	reg  [1:0]  tr_q;
	reg  [1:0]  tr_d;
	reg  [31:0] dom_cnt_q;
	reg  [1:0]  rsp_idx_q;
	reg         lp_q;
	reg  [7:0]  in_now;
	reg  [7:0]  ec_set;
	reg  [7:0]  eff_out;
	reg  [7:0]  drv_val;
	reg  [7:0]  drv_oe;
	reg  [7:0]  rsp_mux;
	reg  [7:0]  latch_d;
	integer     i;
	wire        is_req  = (frame_id_in == request_id_in);  // [RQ23]
	wire        is_rsp  = (frame_id_in == response_id_in); // [RQ23]
	wire        adc_md  = (inhibit_mode_in == `LIOS_IM_ADC);
	wire        dom_to  = (dom_cnt_q >= DOM_TO_CYC - 1);
	wire [1:0]  rsp_max = response_length_select_in ? 2'h3 : 2'h1; // [RQ7]

	always @*
	begin
		latch_d = latch_q;
		for (i = 0; i < 8; i = i + 1)
		begin
			// Cyclic and PWM pins are driven by their own waveforms
			if (req_byte_valid_in && is_req && req_byte_index_in == 2'h0 &&
			    out_mode_in[2*i +: 2] == `LIOS_OM_LEVEL)
				latch_d[i] = req_byte_in[i]; // [RQ1]
			case (out_mode_in[2*i +: 2])
				`LIOS_OM_CYCLIC: eff_out[i] = cyclic_wave_in[i];
				`LIOS_OM_PWM:    eff_out[i] = pwm_wave_in[i];
				default:         eff_out[i] = latch_q[i];
			endcase
			// Both enables off: high impedance; push-pull follows latch, or the waveform in cyclic/PWM mode
			case ({hs_enable_in[i], ls_enable_in[i]})
				2'h1:    begin drv_oe[i] = eff_out[i]; drv_val[i] = 1'b0; end // [RQ8]
				2'h2:    begin drv_oe[i] = eff_out[i]; drv_val[i] = 1'b1; end // [RQ8]
				2'h3:    begin drv_oe[i] = 1'b1; drv_val[i] = eff_out[i]; end // [RQ8]
				default: begin drv_oe[i] = 1'b0; drv_val[i] = 1'b0; end       // [RQ8]
			endcase
			if (!low_threshold_select_in[i])
				in_now[i] = pin_high_th_in[i]; // [RQ10]
			else if (out_mode_in[2*i +: 2] == `LIOS_OM_CYCLIC)
				in_now[i] = pin_diag_th_in[i]; // [RQ11]
			else
				in_now[i] = pin_low_th_in[i]; // [RQ10]
			case (edge_mode_in[2*i +: 2])
				`LIOS_EC_FALL: ec_set[i] = prev_in_q[i] & ~in_now[i]; // [RQ9]
				`LIOS_EC_RISE: ec_set[i] = ~prev_in_q[i] & in_now[i]; // [RQ9]
				`LIOS_EC_BOTH: ec_set[i] = prev_in_q[i] ^ in_now[i];  // [RQ9]
				default:       ec_set[i] = 1'b0;
			endcase
		end
	end

	always @*
	begin
		case (rsp_idx_q)
			2'h0:    rsp_mux = in_now;
			2'h1:    rsp_mux = matrix_enable_in ? matrix_switch_states_in[7:0]
			                                    : edge_capture_flags_out; // [RQ5]
			2'h2:    rsp_mux = matrix_enable_in ? matrix_switch_states_in[15:8]
			                                    : latch_q; // [RQ5]
			default: rsp_mux = adc_md ? adc_result_in : pwm_duty_out; // [RQ6]
		endcase
	end

	always @*
	begin
		tr_d = tr_q;
		case (tr_q)
			`LIOS_TR_OFFLINE: if (bus_wake_in) tr_d = `LIOS_TR_ACTIVE; // [RQ15] [RQ16]
			`LIOS_TR_ACTIVE:  if (dom_to) tr_d = `LIOS_TR_FAILSIL;     // [RQ19]
			`LIOS_TR_FAILSIL: if (bus_rx_in) tr_d = `LIOS_TR_OFFLINE;  // [RQ20]
			default:          tr_d = `LIOS_TR_OFFLINE;
		endcase
		if (sleep_in && tr_d == `LIOS_TR_ACTIVE && tr_q != `LIOS_TR_OFFLINE)
			tr_d = `LIOS_TR_OFFLINE;
	end

	always @(posedge core_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			latch_q <= `LIOS_ZERO8;
			chan_q <= 3'h0;
			prev_in_q <= `LIOS_ZERO8;
			tr_q <= `LIOS_TR_OFFLINE;
			dom_cnt_q <= 32'h0;
			rsp_idx_q <= 2'h0;
			lp_q <= 1'b0;
			pin_out <= `LIOS_ZERO8;
			pin_oe_out <= `LIOS_ZERO8;
			pin_in_out <= `LIOS_ZERO8;
			resp_valid_out <= 1'b0;
			resp_byte_out <= `LIOS_ZERO8;
			resp_last_out <= 1'b0;
			analog_channel_select_out <= 3'h0;
			pwm_duty_out <= `LIOS_ZERO8;
			edge_capture_flags_out <= `LIOS_ZERO8;
			inhibit_hs_on_out <= 1'b1; // [RQ12]
			inhibit_adc_drive_out <= 1'b0;
			config_pins_pullup_out <= 3'h0;
			chain_config_pin_oe_out <= 1'b0;
			tx_enable_out <= 1'b0;
			rx_enable_out <= 1'b0;
			term_resistor_on_out <= 1'b0;
			term_weak_on_out <= 1'b1;
			wake_to_ctrl_out <= 1'b0;
			limp_home_out <= 1'b0;
		end
		else if (clk_en_in)
		begin
			latch_q <= latch_d;
			prev_in_q <= in_now;
			pin_out <= drv_val;
			pin_oe_out <= drv_oe;
			pin_in_out <= in_now;
			lp_q <= low_power_in;
			// Read clears flags, but a new edge in the same cycle survives
			if (resp_valid_out && resp_byte_ack_in && rsp_idx_q == 2'h1 && !matrix_enable_in)
				edge_capture_flags_out <= ec_set; // [RQ9]
			else
				edge_capture_flags_out <= edge_capture_flags_out | ec_set; // [RQ9]
			if (low_power_in && !lp_q)
				pwm_duty_out <= `LIOS_ZERO8; // [RQ24]
			else if (req_byte_valid_in && is_req && req_byte_index_in == 2'h1)
				pwm_duty_out <= req_byte_in;
			if (req_byte_valid_in && is_req && req_byte_index_in == 2'h2 &&
			    request_length_select_in)
				chan_q <= req_byte_in[`LIOS_CH_W-1:0]; // [RQ2] [RQ3]
			if (adc_md)
				analog_channel_select_out <= chan_q; // [RQ4]
			// Response bytes are presented one at a time until acknowledged
			if (resp_start_in && is_rsp && !resp_valid_out)
			begin
				rsp_idx_q <= 2'h0;
				resp_valid_out <= 1'b1;
				resp_last_out <= 1'b0;
				resp_byte_out <= in_now;
			end
			else if (resp_valid_out && resp_byte_ack_in)
			begin
				if (rsp_idx_q == rsp_max) // [RQ7]
				begin
					resp_valid_out <= 1'b0;
					rsp_idx_q <= 2'h0;
				end
				else
					rsp_idx_q <= rsp_idx_q + 2'h1;
			end
			else if (resp_valid_out)
			begin
				resp_byte_out <= rsp_mux;
				resp_last_out <= (rsp_idx_q == rsp_max);
			end
			inhibit_hs_on_out <= (inhibit_mode_in == `LIOS_IM_EXTREG) && !limp_home_out; // [RQ12]
			inhibit_adc_drive_out <= adc_md;
			config_pins_pullup_out <= {3{nad_config_in}}; // [RQ13]
			chain_config_pin_oe_out <= chain_out_in;       // [RQ14]
			// Counter saturates so a stuck bus cannot wrap it
			if (!bus_rx_in && tr_q == `LIOS_TR_ACTIVE && !dom_to)
				dom_cnt_q <= dom_cnt_q + 32'h1;
			else if (bus_rx_in || tr_q != `LIOS_TR_ACTIVE)
				dom_cnt_q <= 32'h0;
			tr_q <= tr_d;
			tx_enable_out <= (tr_d == `LIOS_TR_ACTIVE); // [RQ18]
			rx_enable_out <= (tr_d == `LIOS_TR_ACTIVE); // [RQ15]
			term_resistor_on_out <= (tr_d == `LIOS_TR_ACTIVE); // [RQ19] [RQ21]
			term_weak_on_out <= (tr_d == `LIOS_TR_OFFLINE);    // [RQ20]
			wake_to_ctrl_out <= bus_wake_in && sleep_in;       // [RQ16]
			limp_home_out <= osc_fail_in;                      // [RQ22]
		end
	end
endmodule
`default_nettype wire

// >>> lios_io_slave_props.sv
`timescale 1ns/10ps
`default_nettype none
`include "lios_defines.vh"
module lios_io_props #(
	parameter DOM_TO_CYC = 20
) (
	input wire logic       core_clk_in,
	input wire logic       rst_in,
	input wire logic       clk_en_in,
	input wire logic       bus_rx_in,
	input wire logic       low_power_in,
	input wire logic       nad_config_in,
	input wire logic       osc_fail_in,
	input wire logic       resp_start_in,
	input wire logic [5:0] frame_id_in,
	input wire logic [5:0] response_id_in,
	input wire logic [7:0] hs_enable_in,
	input wire logic [7:0] ls_enable_in,
	input wire logic [1:0] inhibit_mode_in,
	input wire logic       inhibit_hs_on_out,
	input wire logic       term_weak_on_out,
	input wire logic       term_resistor_on_out,
	input wire logic       tx_enable_out,
	input wire logic       resp_valid_out,
	input wire logic       limp_home_out,
	input wire logic [7:0] pwm_duty_out,
	input wire logic [7:0] pin_oe_out,
	input wire logic [2:0] config_pins_pullup_out,
	input wire logic [2:0] analog_channel_select_out
);
	// Saturating count of bus-low cycles; the cap keeps it small on long shorts
	int lo_q;
	always @(posedge core_clk_in or posedge rst_in)
		if (rst_in) lo_q <= 0;
		else if (bus_rx_in) lo_q <= 0;
		else if (clk_en_in && lo_q < DOM_TO_CYC + 4) lo_q <= lo_q + 1;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_not_adc2;
		inhibit_mode_in != `LIOS_IM_ADC ##1 inhibit_mode_in != `LIOS_IM_ADC;
	endsequence
	sequence s_resp_req;
		resp_start_in && clk_en_in && frame_id_in == response_id_in && !resp_valid_out;
	endsequence
	AST_PWR_ON: assert property ($fell(rst_in) |-> inhibit_hs_on_out && term_weak_on_out
		&& !tx_enable_out) else $error("power-on state wrong");
	AST_TX_TERM: assert property (tx_enable_out |-> term_resistor_on_out)
		else $error("tx on without termination");
	AST_DOM_TO: assert property (lo_q >= DOM_TO_CYC + 3 |-> !term_resistor_on_out
		&& !tx_enable_out) else $error("no fail-silent on short");
	AST_PWM_LP: assert property ($rose(low_power_in) && clk_en_in |=> pwm_duty_out == 8'h00)
		else $error("pwm not cleared");
	AST_PU_OFF: assert property (!nad_config_in && clk_en_in |=> config_pins_pullup_out == 3'h0)
		else $error("pull-up outside config");
	AST_PU_ON: assert property (nad_config_in && clk_en_in |=> config_pins_pullup_out == 3'h7)
		else $error("pull-up missing");
	AST_LIMP: assert property (osc_fail_in |-> ##[1:2] limp_home_out)
		else $error("no limp home");
	AST_HIZ: assert property (clk_en_in |=>
		(pin_oe_out & ~$past(hs_enable_in | ls_enable_in)) == 8'h00) else $error("pin driven");
	AST_CHAN: assert property (s_not_adc2 |-> $stable(analog_channel_select_out))
		else $error("channel changed");
	AST_RESP: assert property (s_resp_req |=> resp_valid_out) else $error("no response");
endmodule
bind lios_io_slave lios_io_props #(.DOM_TO_CYC(DOM_TO_CYC)) i_lios_io_props (.*);
`default_nettype wire

// >>> lios_lin_master.sv
`timescale 1ns/10ps
`default_nettype none
module lios_lin_master (
	input  wire logic       core_clk_in,
	input  wire logic       resp_valid_out,
	input  wire logic [7:0] resp_byte_out,
	input  wire logic       resp_last_out,
	output var  logic       req_byte_valid_in,
	output var  logic [1:0] req_byte_index_in,
	output var  logic [7:0] req_byte_in,
	output var  logic       resp_start_in,
	output var  logic       resp_byte_ack_in
);
	logic [7:0] rb [0:3];
	logic [3:0] last;
	int         n_got;
	initial {req_byte_valid_in, req_byte_index_in, req_byte_in, resp_start_in, resp_byte_ack_in} = 13'h0;
	// Data is inverted on release so a stale byte cannot pass for a fresh one
	task send(input logic [1:0] idx, input logic [7:0] b);
		@(negedge core_clk_in) {req_byte_valid_in, req_byte_index_in, req_byte_in} = {1'b1, idx, b};
		@(negedge core_clk_in) req_byte_valid_in = 0;
		req_byte_in = ~b;
	endtask
	task read;
		@(negedge core_clk_in) resp_start_in = 1;
		@(negedge core_clk_in) resp_start_in = 0;
		n_got = 0;
		for (int t = 0; t < 40 && n_got < 4; t++)
		begin
			if (resp_valid_out === 1'b1)
			begin
				rb[n_got] = resp_byte_out;
				last[n_got] = resp_last_out;
				n_got++;
				resp_byte_ack_in = 1;
				@(negedge core_clk_in) resp_byte_ack_in = 0;
				@(negedge core_clk_in);
			end
			@(negedge core_clk_in);
		end
	endtask
endmodule
`default_nettype wire

// >>> lin_io_slave_frames_pins_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "lios_defines.vh"
module lin_io_slave_frames_pins_tb;
	localparam int DOM = 20;
	logic core_clk_in, rst_in, clk_en_in, request_length_select_in, response_length_select_in;
	logic matrix_enable_in, nad_config_in, chain_out_in, bus_rx_in, bus_wake_in, sleep_in;
	logic low_power_in, osc_fail_in, req_byte_valid_in, resp_start_in, resp_byte_ack_in;
	logic [5:0] frame_id_in, request_id_in, response_id_in;
	logic [1:0] req_byte_index_in, inhibit_mode_in;
	logic [15:0] out_mode_in, edge_mode_in, matrix_switch_states_in;
	logic [7:0] req_byte_in, hs_enable_in, ls_enable_in, low_threshold_select_in, pin_high_th_in;
	logic [7:0] pin_low_th_in, pin_diag_th_in, pwm_wave_in, cyclic_wave_in, adc_result_in;
	wire [7:0] pin_out, pin_oe_out, pin_in_out, resp_byte_out, pwm_duty_out, edge_capture_flags_out;
	wire [2:0] analog_channel_select_out, config_pins_pullup_out;
	wire resp_valid_out, resp_last_out, inhibit_hs_on_out, inhibit_adc_drive_out;
	wire chain_config_pin_oe_out, tx_enable_out, rx_enable_out, term_resistor_on_out;
	wire term_weak_on_out, wake_to_ctrl_out, limp_home_out;
	int err_count, n_checks, k;
	logic [7:0] d0, d1, d2, lvl, oe;
	logic [2:0] ch, cq;
	lios_io_slave #(.DOM_TO_CYC(DOM)) i_lios_io_slave (.*);
	lios_lin_master i_lios_lin_master (.*);
	initial
	begin
		core_clk_in = 0;
		forever #10 core_clk_in = ~core_clk_in;
	end
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task summarize;
		if (err_count == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	function automatic logic [7:0] exp_in();
		for (int p = 0; p < 8; p++)
			exp_in[p] = !low_threshold_select_in[p] ? pin_high_th_in[p] :
				(out_mode_in[2*p+:2] == `LIOS_OM_CYCLIC ? pin_diag_th_in[p] : pin_low_th_in[p]);
	endfunction
	task rnd;
		for (int i = 0; i < 8; i++) out_mode_in[2*i+:2] = $urandom % 3;
		{hs_enable_in, ls_enable_in, low_threshold_select_in} = $urandom;
		{pin_high_th_in, pin_low_th_in, pin_diag_th_in, pwm_wave_in} = $urandom;
		{matrix_switch_states_in, cyclic_wave_in, adc_result_in} = $urandom;
		inhibit_mode_in = $urandom % 3;
		{matrix_enable_in, request_length_select_in, response_length_select_in} = $urandom;
	endtask
	task frame(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		frame_id_in = request_id_in;
		i_lios_lin_master.send(2'h0, a);
		i_lios_lin_master.send(2'h1, b);
		if (request_length_select_in) i_lios_lin_master.send(2'h2, c);
		frame_id_in = response_id_in;
		i_lios_lin_master.read;
	endtask
	initial
	begin
		k = $urandom(72);
		{rst_in, clk_en_in, bus_rx_in, nad_config_in, chain_out_in} = 5'h1c;
		{bus_wake_in, sleep_in, low_power_in, osc_fail_in, frame_id_in} = 10'h000;
		// Edge modes cycle none, fall, rise, both across the pins
		{request_id_in, response_id_in, edge_mode_in} = {6'h11, 6'h22, 16'he4e4};
		rnd;
		repeat (6) @(negedge core_clk_in);
		rst_in = 0;
		ch = 3'h0;
		cq = 3'h0;
		for (k = 0; k < 14; k++)
		begin
			@(negedge core_clk_in) rnd;
			{d0, d1, d2} = $urandom;
			frame(d0, d1, d2);
			for (int i = 0; i < 8; i++) lvl[i] = out_mode_in[2*i+:2] == `LIOS_OM_LEVEL;
			// A channel sent outside ADC mode is kept and applied once ADC mode is on
			if (request_length_select_in) cq = d2[2:0];
			if (inhibit_mode_in == `LIOS_IM_ADC) ch = cq;
			chk(analog_channel_select_out, ch);
			chk(inhibit_adc_drive_out, inhibit_mode_in == `LIOS_IM_ADC);
			chk(pin_in_out, exp_in());
			chk(i_lios_lin_master.n_got, response_length_select_in ? 4 : 2);
			chk(i_lios_lin_master.last[1], !response_length_select_in);
			chk(i_lios_lin_master.rb[0], exp_in());
			if (matrix_enable_in) chk(i_lios_lin_master.rb[1], matrix_switch_states_in[7:0]);
			if (response_length_select_in)
			begin
				chk(i_lios_lin_master.rb[2] & (matrix_enable_in ? 8'hff : lvl),
					matrix_enable_in ? matrix_switch_states_in[15:8] : d0 & lvl);
				chk(i_lios_lin_master.rb[3], inhibit_mode_in == `LIOS_IM_ADC ? adc_result_in : d1);
			end
			oe = (hs_enable_in & ls_enable_in) | ((hs_enable_in ^ ls_enable_in) & d0);
			chk(pin_oe_out & lvl, oe & lvl);
			chk(pin_out & oe & lvl, hs_enable_in & d0 & oe & lvl);
			chk(pwm_duty_out, d1);
		end
		{out_mode_in, low_threshold_select_in, matrix_enable_in} = 25'h0;
		for (k = 0; k < 3; k++)
		begin
			pin_high_th_in = {8{k[0]}};
			repeat (3) @(negedge core_clk_in);
			frame(8'h00, 8'h5a, 8'h00);
			if (k > 0) chk(i_lios_lin_master.rb[1], k == 1 ? 8'hcc : 8'haa);
		end
		low_power_in = 1;
		repeat (2) @(negedge core_clk_in);
		chk(pwm_duty_out, 8'h00);
		low_power_in = 0;
		frame_id_in = 6'h3f;
		i_lios_lin_master.send(2'h1, 8'h77);
		chk(pwm_duty_out, 8'h00);
		sleep_in = 1;
		repeat (2) @(negedge core_clk_in);
		chk({tx_enable_out, rx_enable_out}, 2'h0);
		bus_wake_in = 1;
		@(negedge core_clk_in);
		chk(wake_to_ctrl_out, 1'b1);
		bus_wake_in = 0;
		sleep_in = 0;
		repeat (2) @(negedge core_clk_in);
		chk({tx_enable_out, term_resistor_on_out, rx_enable_out}, 3'h7);
		bus_rx_in = 0;
		repeat (DOM + 4) @(negedge core_clk_in);
		chk({tx_enable_out, term_resistor_on_out}, 2'h0);
		bus_rx_in = 1;
		repeat (3) @(negedge core_clk_in);
		chk({tx_enable_out, term_weak_on_out}, 2'h1);
		{nad_config_in, chain_out_in, osc_fail_in} = 3'h7;
		repeat (3) @(negedge core_clk_in);
		chk({config_pins_pullup_out, chain_config_pin_oe_out, limp_home_out}, 5'h1f);
		summarize;
	end
endmodule
`default_nettype wire
